// File: rtl/rtc_pwr_pkg.sv
// Operation
// RULE1: external source holds wake high one slow period
// RULE2: powerdown bit switches regulator off, power-good low
// RULE3: external supplies restored before wake pulse starts
// RULE4: power-good stays low until regulator voltage good
// RULE5: voltage good raises power-good, resets system, unisolates
// RULE6: level bit zero drives wake pin low
// RULE7: direction bit selects input or open-drain output
// RULE8: wake pin wakes only while configured input
// RULE9: reference powerdown stops regulators, reset and bandgap
// RULE10: wake pin or alarm re-enables after powerdown
// RULE11: bandgap needs settling time after re-enable
// RULE12: software avoids powerdown bits with bypassed regulators
// RULE13: reserved bits read zero, writes ignored
// RULE14: regulator powerdown keeps bandgap running
// RULE15: clock output enable bit gates slow-clock output
// RULE16: wake input synchronised, held one period counts
package rtc_pwr_pkg;

  // register byte addresses on the lite bus
  localparam logic [15:0] CTRL_ADDR = 16'h1930;
  localparam logic [15:0] STATUS_ADDR = 16'h1934;

  // control register field positions and width
  localparam int CLKOUT_BIT = 0;
  localparam int REG_PD_BIT = 1;
  localparam int REF_PD_BIT = 2;
  localparam int WAKE_DIR_BIT = 3;
  localparam int WAKE_LVL_BIT = 4;
  localparam int CTRL_W = 5;
  localparam logic [4:0] CTRL_RESET = 5'h10;

  // status register field positions
  localparam int STAT_STATE_LSB = 0;
  localparam int STAT_PGOOD_BIT = 3;
  localparam int STAT_WAKE_BIT = 4;
  localparam int STAT_VOK_BIT = 5;

  // bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // timing: clock rate and documented figures in their own units
  localparam int CLK_HZ = 20000000;
  localparam int WAKE_MIN_NS = 30500;
  localparam int BG_SETTLE_MS = 100;
  localparam int SYS_RESET_CYC = 16;
  // least time, rounded up to whole cycles
  localparam int WAKE_MIN_CYC = (WAKE_MIN_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int BG_SETTLE_CYC = BG_SETTLE_MS * (CLK_HZ / 1000);

  // register selection codes
  typedef enum logic [1:0] {
    SEL_NONE = 2'b00,
    SEL_CTRL = 2'b01,
    SEL_STAT = 2'b10
  } reg_sel_e;

  // power sequencer states
  typedef enum logic [2:0] {
    ST_RUN = 3'b000,
    ST_DOWN = 3'b001,
    ST_BG_SETTLE = 3'b010,
    ST_RAMP = 3'b011,
    ST_SYS_RESET = 3'b100
  } seq_state_e;

  // control register fields, bit 4 down to bit 0
  typedef struct packed {
    logic wake_pin_out_level;
    logic wake_pin_direction;
    logic reference_powerdown;
    logic regulator_powerdown;
    logic slow_clock_out_enable;
  } ctrl_s;

  // power controls toward the analog domain
  typedef struct packed {
    logic core_regulator_output;
    logic analog_por_enable;
    logic bandgap_enable;
    logic power_good;
    logic isolation;
    logic system_reset_n;
  } power_s;

endpackage : rtc_pwr_pkg

// File: rtl/rtc_only_power_sequencer.sv
// Our own choice: the AXI4-Lite slave port.
`timescale 1ns/1ns
`default_nettype none
module rtc_only_power_sequencer #(
  // bus address width; only a full match selects a register
  parameter int ADDR_W = 16,
  // reference settle time in cycles; shorten only for simulation
  parameter int BG_SETTLE_CYCLES = rtc_pwr_pkg::BG_SETTLE_CYC,
  // length of the system reset pulse after power-good rises
  parameter int RESET_CYCLES = rtc_pwr_pkg::SYS_RESET_CYC
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // lite bus write address
  input wire logic awvalid,
  output var logic awready,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  // lite bus write data
  input wire logic wvalid,
  output var logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // lite bus write response
  output var logic bvalid,
  input wire logic bready,
  output var logic [1:0] bresp,
  // lite bus read address
  input wire logic arvalid,
  output var logic arready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  // lite bus read data
  output var logic rvalid,
  input wire logic rready,
  output var logic [31:0] rdata,
  output var logic [1:0] rresp,
  // wake pin, open-drain capable
  input wire logic wake_pin_in,
  output var logic wake_pin_out,
  output var logic wake_pin_oe,
  // alarm event from calendar logic, same clock
  input wire logic alarm_event,
  // regulator voltage monitor, asynchronous
  input wire logic regulator_voltage_ok,
  // power controls and clock output gate
  output var rtc_pwr_pkg::power_s power_ctl,
  output var logic slow_clock_out_enable
);
  import rtc_pwr_pkg::*;

  // decode a byte address into a register select
  // shared by the read and write paths so both agree on the map
  function automatic reg_sel_e reg_sel(input logic [ADDR_W-1:0] addr);
    // full compare, so aliases of a register answer as unmapped
    if (addr == ADDR_W'(CTRL_ADDR)) begin
      return SEL_CTRL;
    end else if (addr == ADDR_W'(STATUS_ADDR)) begin
      return SEL_STAT;
    end else begin
      return SEL_NONE;
    end
  endfunction : reg_sel

  // control register and sequencer state
  ctrl_s ctrl_q;
  seq_state_e state_q;
  // 32-bit timers so the full settle time fits at any clock rate
  logic [31:0] cnt_q;          // settle and reset pulse timer
  logic [31:0] wake_cnt_q;     // high-level duration on the wake pin
  logic wake_seen_q;           // wake held long enough
  // synchronisers: first stage read only by second stage
  logic wake_s1_q;
  logic wake_s2_q;
  logic vok_s1_q;
  logic vok_s2_q;
  // write channel capture
  logic aw_have_q;
  logic [ADDR_W-1:0] aw_addr_q;
  logic w_have_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  // wake and write conditions
  logic wake_req;
  logic do_write;
  logic write_ok;

  // pin inputs pass two flops before any logic reads them
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      // clear to the idle level of both pins so no false wake follows reset
      wake_s1_q <= 1'b0;
      wake_s2_q <= 1'b0;
      vok_s1_q <= 1'b0;
      vok_s2_q <= 1'b0;
    end else begin
      // one flop catches the pin, the second lets a metastable value settle
      wake_s1_q <= wake_pin_in;    // RULE16
      wake_s2_q <= wake_s1_q;      // RULE16
      vok_s1_q <= regulator_voltage_ok;
      vok_s2_q <= vok_s1_q;
    end
  end

  // measure how long the wake pin has been high; a short glitch never wakes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      // no wake may be pending after reset
      wake_cnt_q <= 32'h0000_0000;
      wake_seen_q <= 1'b0;
    end else if (!wake_s2_q || ctrl_q.wake_pin_direction) begin
      // low pin, or pin used as output: restart the measurement
      wake_cnt_q <= 32'h0000_0000;
      wake_seen_q <= 1'b0;
    end else if (wake_cnt_q < 32'(WAKE_MIN_CYC - 1)) begin
      // still short of one slow-clock period
      wake_cnt_q <= wake_cnt_q + 32'h0000_0001;
    end else begin
      wake_seen_q <= 1'b1;         // RULE16 RULE1
    end
  end

  // pin only wakes as an input; the alarm wakes in either direction
  // the alarm comes from logic on this clock, so it needs no synchroniser
  assign wake_req = (wake_seen_q && !ctrl_q.wake_pin_direction) || alarm_event; // RULE8 RULE10

  // write address: ready offered one cycle after valid, then captured
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      // idle bus after reset
      awready <= 1'b0;
      aw_have_q <= 1'b0;
      aw_addr_q <= '0;
    end else begin
      // single-cycle ready; a held address blocks the next one
      awready <= awvalid && !awready && !aw_have_q && !bvalid;
      if (awvalid && awready) begin
        // address kept until the data half has arrived too
        aw_have_q <= 1'b1;
        aw_addr_q <= awaddr;
      end else if (do_write) begin
        aw_have_q <= 1'b0;
      end
    end
  end

  // write data: captured independently of the address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      // idle bus after reset
      wready <= 1'b0;
      w_have_q <= 1'b0;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
    end else begin
      // same one-cycle ready as the address channel
      wready <= wvalid && !wready && !w_have_q && !bvalid;
      if (wvalid && wready) begin
        // data and strobes kept until the address half has arrived
        w_have_q <= 1'b1;
        w_data_q <= wdata;
        w_strb_q <= wstrb;
      end else if (do_write) begin
        w_have_q <= 1'b0;
      end
    end
  end

  // a write completes once both halves are held
  // the previous answer must be taken before the next write lands
  assign do_write = aw_have_q && w_have_q && !bvalid;
  // control writes are refused while the clock domain is isolated
  assign write_ok = reg_sel(aw_addr_q) == SEL_CTRL && !power_ctl.isolation;

  // write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end else if (do_write) begin
      // status, unmapped and isolated writes are refused
      bvalid <= 1'b1;
      bresp <= write_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (bvalid && bready) begin
      // answer and code stood until the master took them
      bvalid <= 1'b0;
    end
  end

  // control register: software writes, sequencer clears powerdown on wake
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      // level bit set: the pin starts released, as an input
      ctrl_q <= ctrl_s'(CTRL_RESET);
    end else if (do_write && write_ok && w_strb_q[0]) begin
      // only bits 4..0 exist; upper lanes are discarded
      ctrl_q <= ctrl_s'(w_data_q[CTRL_W-1:0]);   // RULE13
    end else if (state_q == ST_DOWN && wake_req) begin
      // powerdown bits drop so the restored core does not fall again
      ctrl_q.regulator_powerdown <= 1'b0;        // RULE10
      ctrl_q.reference_powerdown <= 1'b0;        // RULE10
    end
  end

  // read channel: one cycle to ready, next cycle data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      // idle bus after reset
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= RESP_OKAY;
    end else begin
      arready <= arvalid && !arready && !rvalid;
      if (arvalid && arready) begin
        // data taken from the register state at the handshake
        rvalid <= 1'b1;
        rresp <= RESP_OKAY;
        rdata <= 32'h0000_0000;   // RULE13
        if (reg_sel(araddr) == SEL_CTRL) begin
          rdata[CTRL_W-1:0] <= ctrl_q;
        end else if (reg_sel(araddr) == SEL_STAT) begin
          // live view of the sequencer and both synchronised inputs
          rdata[STAT_STATE_LSB +: 3] <= state_q;
          rdata[STAT_PGOOD_BIT] <= power_ctl.power_good;
          rdata[STAT_WAKE_BIT] <= wake_s2_q;
          rdata[STAT_VOK_BIT] <= vok_s2_q;
        end else begin
          rresp <= RESP_SLVERR;    // unmapped address
        end
      end else if (rvalid && rready) begin
        // data stood until the master took them
        rvalid <= 1'b0;
      end
    end
  end

  // power sequencer; after the slow-domain reset the core ramps up first
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      // first power-up waits for a good voltage like any other wake
      state_q <= ST_RAMP;
      cnt_q <= 32'h0000_0000;
    end else begin
      case (state_q)
        ST_RUN: begin
          // normal operation: watch for powerdown or a sagging supply
          cnt_q <= 32'h0000_0000;
          if (ctrl_q.regulator_powerdown || ctrl_q.reference_powerdown) begin
            // either bit starts the same shutdown
            state_q <= ST_DOWN;      // RULE2 RULE9 RULE14
          end else if (!vok_s2_q) begin
            // core supply sagged: fall back to isolation until it recovers
            state_q <= ST_RAMP;
          end
        end
        ST_DOWN: begin
          // regulators off; only a wake request leaves
          cnt_q <= 32'h0000_0000;
          if (wake_req) begin
            // bandgap was off only on the reference path
            state_q <= ctrl_q.reference_powerdown ? ST_BG_SETTLE : ST_RAMP; // RULE10 RULE14
          end
        end
        ST_BG_SETTLE: begin
          // regulators wait for the reference capacitor to charge
          // the clock domain stays isolated through the whole settle
          if (cnt_q >= 32'(BG_SETTLE_CYCLES - 1)) begin
            cnt_q <= 32'h0000_0000;
            state_q <= ST_RAMP;      // RULE11
          end else begin
            cnt_q <= cnt_q + 32'h0000_0001;
          end
        end
        ST_RAMP: begin
          // isolation held until the monitored voltage crosses threshold
          cnt_q <= 32'h0000_0000;
          if (vok_s2_q) begin
            state_q <= ST_SYS_RESET; // RULE4 RULE5
          end
        end
        ST_SYS_RESET: begin
          // hold the rest of the system in reset for a fixed pulse
          if (cnt_q >= 32'(RESET_CYCLES - 1)) begin
            cnt_q <= 32'h0000_0000;
            state_q <= ST_RUN;       // RULE5
          end else begin
            // count out the reset pulse
            cnt_q <= cnt_q + 32'h0000_0001;
          end
        end
        default: begin
          // unused codes recover through the ramp
          cnt_q <= 32'h0000_0000;
          state_q <= ST_RAMP;
        end
      endcase
    end
  end

  // power controls follow the sequencer state, one cycle later
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      // power-on state: supply up, system held, domain isolated
      power_ctl.core_regulator_output <= 1'b1;
      power_ctl.analog_por_enable <= 1'b1;
      power_ctl.bandgap_enable <= 1'b1;
      power_ctl.power_good <= 1'b0;
      power_ctl.isolation <= 1'b1;
      power_ctl.system_reset_n <= 1'b0;
    end else begin
      // regulator also held off while the reference settles; it needs the bandgap
      power_ctl.core_regulator_output <= state_q != ST_DOWN && state_q != ST_BG_SETTLE; // RULE11
      // analog reset is back at once so it can watch the coming ramp
      power_ctl.analog_por_enable <= state_q != ST_DOWN;       // RULE9 RULE14
      // bandgap off only on the reference powerdown path
      power_ctl.bandgap_enable <= !(state_q == ST_DOWN && ctrl_q.reference_powerdown); // RULE9 RULE14
      // power-good high only once the voltage has been seen good
      power_ctl.power_good <= state_q == ST_RUN || state_q == ST_SYS_RESET; // RULE4 RULE5
      power_ctl.isolation <= !(state_q == ST_RUN || state_q == ST_SYS_RESET); // RULE2 RULE5
      // system leaves reset one cycle after the sequencer reaches run
      power_ctl.system_reset_n <= state_q == ST_RUN;           // RULE5
    end
  end

  // wake pin driver and slow clock output gate
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      // pin released and clock output gated until software asks
      wake_pin_out <= 1'b0;
      wake_pin_oe <= 1'b0;
      slow_clock_out_enable <= 1'b0;
    end else begin
      // open-drain: only ever drives low, released when level bit is 1
      wake_pin_out <= 1'b0;                                                 // RULE6
      wake_pin_oe <= ctrl_q.wake_pin_direction && !ctrl_q.wake_pin_out_level; // RULE6 RULE7
      // registered copy keeps the gate free of decode glitches
      slow_clock_out_enable <= ctrl_q.slow_clock_out_enable;                // RULE15
    end
  end

endmodule : rtc_only_power_sequencer
`default_nettype wire

// File: tb/rtc_pwr_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module rtc_pwr_monitor (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // bus answers
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [1:0] bresp,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [31:0] rdata,
  // pins and power
  input wire logic wake_pin_out,
  input wire logic wake_pin_oe,
  input wire logic regulator_voltage_ok,
  input wire rtc_pwr_pkg::power_s power_ctl,
  input wire logic slow_clock_out_enable
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // open drain only ever pulls low
  property p_od_low; wake_pin_out == 1'b0; endproperty
  a_od_low: assert property (p_od_low) else $error("wake pin driven high");
  property p_pg_free; power_ctl.power_good |-> !power_ctl.isolation; endproperty
  a_pg_free: assert property (p_pg_free) else $error("isolated with power good");
  // three cycles of sync and state lag before power good may follow the monitor
  property p_pg_vok;
    $rose(power_ctl.power_good) |-> $past(regulator_voltage_ok, 3) && power_ctl.core_regulator_output;
  endproperty
  a_pg_vok: assert property (p_pg_vok) else $error("power good before voltage");
  property p_down;
    !power_ctl.core_regulator_output |-> !power_ctl.power_good && power_ctl.isolation
      && !power_ctl.system_reset_n;
  endproperty
  a_down: assert property (p_down) else $error("regulator off but not isolated");
  property p_ref; !power_ctl.bandgap_enable |-> !power_ctl.core_regulator_output; endproperty
  a_ref: assert property (p_ref) else $error("regulator on without reference");
  // the regulator stays off while a returning reference settles
  property p_bgset; $rose(power_ctl.bandgap_enable) |-> !power_ctl.core_regulator_output [*8];
  endproperty
  a_bgset: assert property (p_bgset) else $error("regulator on during settle");
  property p_sysrst; $rose(power_ctl.power_good) |-> !power_ctl.system_reset_n [*8]; endproperty
  a_sysrst: assert property (p_sysrst) else $error("system reset too short");
  // config outputs move only after a completed write
  property p_clkout; $changed(slow_clock_out_enable) |-> $past(bvalid, 1) || $past(bvalid, 2);
  endproperty
  a_clkout: assert property (p_clkout) else $error("clock out moved alone");
  property p_oe; $changed(wake_pin_oe) |-> $past(bvalid, 1) || $past(bvalid, 2); endproperty
  a_oe: assert property (p_oe) else $error("wake enable moved alone");
  property p_bhold; bvalid && !bready |=> bvalid && $stable(bresp); endproperty
  a_bhold: assert property (p_bhold) else $error("write answer dropped");
  property p_rhold; rvalid && !rready |=> rvalid && $stable(rdata); endproperty
  a_rhold: assert property (p_rhold) else $error("read answer dropped");
  property p_rans; arvalid && arready |-> ##[1:4] rvalid; endproperty
  a_rans: assert property (p_rans) else $error("read not answered");
  c_pg: cover property ($rose(power_ctl.power_good));
  c_off: cover property ($fell(power_ctl.core_regulator_output));
  c_oe: cover property ($rose(wake_pin_oe));
endmodule : rtc_pwr_monitor
bind rtc_only_power_sequencer rtc_pwr_monitor u_mon (.aclk, .aresetn, .bvalid, .bready,
  .bresp, .arvalid, .arready, .rvalid, .rready, .rdata, .wake_pin_out, .wake_pin_oe,
  .regulator_voltage_ok, .power_ctl, .slow_clock_out_enable);
`default_nettype wire

// File: tb/rtc_supply_model.sv
`timescale 1ns/1ns
`default_nettype none
module rtc_supply_model #(
  parameter int RAMP = 100
) (
  // clock
  input wire logic aclk,
  // device side
  input wire logic regulator_on,
  input wire logic wake_pin_oe,
  output var logic wake_pin_in,
  output var logic voltage_ok,
  // bench side: wake source and board pull-up
  input wire logic wake_drive,
  input wire logic pull_up
);
  int ramp_q; // cycles since regulator on
  // supplies are already back, so only the core ramp delays the monitor
  always_ff @(posedge aclk) begin
    if (!regulator_on) ramp_q <= 0;
    else if (ramp_q < RAMP) ramp_q <= ramp_q + 1;
  end
  assign voltage_ok = regulator_on && (ramp_q >= RAMP);
  // wired pin: device pull-down beats source and pull-up
  assign wake_pin_in = !wake_pin_oe && (wake_drive || pull_up);
endmodule : rtc_supply_model
`default_nettype wire

// File: tb/rtc_only_power_sequencer_test.sv
`timescale 1ns/1ns
`default_nettype none
module rtc_only_power_sequencer_test;
  import rtc_pwr_pkg::*;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, alarm_event;
  logic awready, wready, bvalid, arready, rvalid, wake_pin_in, wake_pin_out, wake_pin_oe;
  logic vok, wake_drive, pull_up, sce;
  logic [15:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp;
  power_s power_ctl;
  int errors, n_compared;

  // bench settle count kept short
  rtc_only_power_sequencer #(.BG_SETTLE_CYCLES(20)) uut (.aclk, .aresetn, .awvalid, .awready,
    .awaddr, .awprot(3'h0), .wvalid, .wready, .wdata, .wstrb(4'hf), .bvalid, .bready, .bresp,
    .arvalid, .arready, .araddr, .arprot(3'h0), .rvalid, .rready, .rdata, .rresp, .wake_pin_in,
    .wake_pin_out, .wake_pin_oe, .alarm_event, .regulator_voltage_ok(vok), .power_ctl,
    .slow_clock_out_enable(sce));
  rtc_supply_model #(.RAMP(100)) far (.aclk, .regulator_on(power_ctl.core_regulator_output),
    .wake_pin_oe, .wake_pin_in, .voltage_ok(vok), .wake_drive, .pull_up);

  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end

  task automatic end_of_test;
    if (errors == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // a used-up wait ends the run
  task automatic guard(input int n);
    if (n >= 3000) begin
      errors++;
      $display("mismatch at %0t: wait timed out", $time);
      end_of_test();
    end
  endtask : guard

  // power_ctl bit: 5 regulator, 3 bandgap, 2 power good, 0 system reset
  task automatic wait_ctl(input int i, input logic v);
    int n;
    n = 0;
    while (power_ctl[i] !== v && n < 3000) begin
      @(posedge aclk);
      n++;
    end
    guard(n);
  endtask : wait_ctl

  task automatic wchk(input logic [15:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      n++;
    end while (((awvalid && !awready) || (wvalid && !wready)) && n < 3000);
    // ready raised late so a held answer is exercised
    while (bvalid !== 1'b1 && n < 3000) begin
      @(posedge aclk);
      n++;
    end
    guard(n);
    bready <= 1'b1;
    @(posedge aclk);
    chk(bresp, er);
    bready <= 1'b0;
  endtask : wchk

  task automatic rchk(input logic [15:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      n++;
    end while (!arready && n < 3000);
    while (rvalid !== 1'b1 && n < 3000) begin
      @(posedge aclk);
      n++;
    end
    guard(n);
    rready <= 1'b1;
    @(posedge aclk);
    chk(rdata, ed);
    chk(rresp, er);
    rready <= 1'b0;
  endtask : rchk

  task automatic pulse(input int n);
    wake_drive <= 1'b1;
    repeat (n) @(posedge aclk);
    wake_drive <= 1'b0;
    @(posedge aclk);
  endtask : pulse

  task automatic alarm;
    alarm_event <= 1'b1;
    @(posedge aclk);
    alarm_event <= 1'b0;
  endtask : alarm

  initial begin
    errors = 0;
    n_compared = 0;
    {aresetn, awvalid, wvalid, bready, arvalid, rready, alarm_event, wake_drive} = 8'h00;
    pull_up = 1'b0;
    awaddr = 16'h0000;
    araddr = 16'h0000;
    wdata = 32'h0000_0000;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    wait_ctl(0, 1'b1);
    rchk(CTRL_ADDR, 32'h0000_0010, RESP_OKAY);
    chk(wake_pin_oe, 1'b0);
    rchk(16'h1938, 32'h0000_0000, RESP_SLVERR);
    // status: run state, power good, wake pin low, voltage good
    rchk(STATUS_ADDR, 32'h0000_0028, RESP_OKAY);
    wchk(STATUS_ADDR, 32'h0000_0000, RESP_SLVERR);
    wchk(CTRL_ADDR, 32'hffff_ffe1, RESP_OKAY);
    rchk(CTRL_ADDR, 32'h0000_0001, RESP_OKAY);
    chk(sce, 1'b1);
    // output mode pulls the pin low against the pull-up
    wchk(CTRL_ADDR, 32'h0000_0008, RESP_OKAY);
    pull_up <= 1'b1;
    repeat (3) @(posedge aclk);
    chk({wake_pin_oe, wake_pin_out, wake_pin_in, sce}, 4'h8);
    // the model's supply is the device's own regulator, never bypassed
    wchk(CTRL_ADDR, 32'h0000_001a, RESP_OKAY);
    repeat (3) @(posedge aclk);
    chk(power_ctl, 6'h0a);
    wchk(CTRL_ADDR, 32'h0000_0018, RESP_SLVERR);
    pulse(650);
    chk(power_ctl[5], 1'b0);
    pull_up <= 1'b0;
    alarm();
    wait_ctl(0, 1'b1);
    rchk(CTRL_ADDR, 32'h0000_0018, RESP_OKAY);
    wchk(CTRL_ADDR, 32'h0000_0012, RESP_OKAY);
    repeat (3) @(posedge aclk);
    pulse(100);
    chk(power_ctl[5], 1'b0);
    pulse(650);
    chk({power_ctl[5], power_ctl.power_good}, 2'h2);
    wait_ctl(2, 1'b1);
    chk(power_ctl.isolation, 1'b0);
    wait_ctl(0, 1'b1);
    wchk(CTRL_ADDR, 32'h0000_0014, RESP_OKAY);
    repeat (3) @(posedge aclk);
    chk(power_ctl, 6'h02);
    alarm();
    repeat (10) @(posedge aclk);
    chk({power_ctl[5], power_ctl[3]}, 2'h1);
    wait_ctl(0, 1'b1);
    rchk(CTRL_ADDR, 32'h0000_0010, RESP_OKAY);
    end_of_test();
  end
endmodule : rtc_only_power_sequencer_test
`default_nettype wire
